// *** hdl/pin_cell.v ***
`timescale 1ns/1ps
`default_nettype none
// One pad's output stage: function override, open-drain and pull-up gating.
module pin_cell (
  // Clock and reset
  input  wire i_ref_clk,
  input  wire i_srst,
  // Port register side
  input  wire i_port_data,
  input  wire i_port_dir,
  input  wire i_pullup_sel,
  input  wire i_open_drain,
  // Function side
  input  wire i_fn_own,
  input  wire i_fn_data,
  input  wire i_fn_oe,
  // Pad side
  output reg  o_pad_out_ff,
  output reg  o_pad_oe_ff,
  output reg  o_pullup_ff
);
  reg nxt_out;
  reg nxt_oe;

  // The owning function wins over the port registers; release hands back control.
  always @* begin
    nxt_out = i_fn_own ? i_fn_data : i_port_data;
    nxt_oe  = i_fn_own ? i_fn_oe : i_port_dir;
    // Open drain never drives a one; it only lets go of the line.
    if (i_open_drain && nxt_out) begin
      nxt_oe = 1'b0;
    end
  end

  // Registered so every pad signal comes straight from a flip-flop.
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_pad_out_ff <= 1'b0;
      o_pad_oe_ff  <= 1'b0;
      o_pullup_ff  <= 1'b0;
    end else begin
      o_pad_out_ff <= nxt_out;
      o_pad_oe_ff  <= nxt_oe;
      o_pullup_ff  <= i_pullup_sel & ~nxt_oe;
    end
  end
endmodule
`default_nettype wire

// *** hdl/port_bus_pin_function_select.v ***
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_defines.vh"
// Pin-function selection for ports 0 to 5 with external-bus multiplexing.
module port_bus_pin_function_select (
  // Clock, reset, standby and mode pins
  input  wire        i_ref_clk,
  input  wire        i_srst,
  input  wire        i_hw_standby_input,
  input  wire [2:0]  i_mode_select_inputs,
  // Port registers, six ports of eight bits
  input  wire [47:0] i_port_data,
  input  wire [47:0] i_port_dir,
  input  wire [7:0]  i_port0_pullup_select,
  input  wire [7:0]  i_port1_pullup_select,
  input  wire [7:0]  i_port4_open_drain_select,
  // Bus controller
  input  wire [23:0] i_bus_addr,
  input  wire [15:0] i_bus_wdata,
  input  wire        i_bus_addr_phase,
  input  wire        i_bus_data_drive,
  input  wire        i_bus_ale,
  input  wire        i_bus_rd,
  input  wire        i_bus_write_strobe_low_byte,
  input  wire        i_bus_write_strobe_high_byte,
  input  wire        i_bus_released,
  input  wire        i_bus_clk,
  // Peripherals
  input  wire        i_async0_tx,
  input  wire        i_async0_tx_en,
  input  wire        i_async0_clk,
  input  wire        i_async0_clk_en,
  input  wire        i_async1_tx,
  input  wire        i_async1_tx_en,
  input  wire        i_async1_clk,
  input  wire        i_async1_clk_en,
  input  wire [1:0]  i_pulse_out_pair,
  input  wire [1:0]  i_pulse_out_en,
  input  wire        i_clocked0_tx,
  input  wire        i_clocked0_clk,
  input  wire        i_clocked0_en,
  // Pads
  input  wire [47:0] i_pad_in,
  output wire [47:0] o_pad_out,
  output wire [47:0] o_pad_oe,
  output wire [15:0] o_pad_pullup,
  // Decoded inputs back to the core and peripherals
  output reg  [47:0] o_port_read_ff,
  output reg  [15:0] o_bus_rdata_ff,
  output reg         o_hold_request_ff,
  output reg         o_bus_ready_ff,
  output reg         o_ext_bus_mode_ff,
  output reg         o_hw_standby_ff,
  output reg         o_async0_rx_ff,
  output reg         o_async1_rx_ff,
  output reg         o_async0_clk_in_ff,
  output reg         o_async1_clk_in_ff,
  output reg         o_clocked0_rx_ff,
  output reg         o_clocked1_rx_ff
);
  reg  [47:0] fn_own;
  reg  [47:0] fn_data;
  reg  [47:0] fn_oe;
  wire [47:0] pullup_sel;
  wire [47:0] open_drain;
  wire [15:0] pullup_all;
  wire        ext;

  // The mode pins are static straps; a decoded flag is kept current anyway.
  assign ext = (i_mode_select_inputs == `PM_MODE_EXT_BUS);

  // Only ports 0 and 1 have pull-ups; only port 4 has open-drain controls.
  assign pullup_sel = {32'h0000_0000, i_port1_pullup_select, i_port0_pullup_select};
  assign open_drain = {8'h00, i_port4_open_drain_select, 32'h0000_0000};
  assign o_pad_pullup = pullup_all;

  // Per-pin ownership, value and enable from the active functions.
  always @* begin
    fn_own  = 48'h0000_0000_0000;
    fn_data = 48'h0000_0000_0000;
    fn_oe   = 48'h0000_0000_0000;
    if (ext) begin
      // Port 0: low address during the address phase, then low data.
      fn_own[7:0]   = 8'hff;
      fn_data[7:0]  = i_bus_addr_phase ? i_bus_addr[7:0] : i_bus_wdata[7:0];
      fn_oe[7:0]    = {8{i_bus_addr_phase | i_bus_data_drive}} & {8{~i_bus_released}};
      // Port 1: middle address, then high data.
      fn_own[15:8]  = 8'hff;
      fn_data[15:8] = i_bus_addr_phase ? i_bus_addr[15:8] : i_bus_wdata[15:8];
      fn_oe[15:8]   = {8{i_bus_addr_phase | i_bus_data_drive}} & {8{~i_bus_released}};
      // Port 2: high address byte, floated while the bus is handed over.
      fn_own[23:16]  = 8'hff;
      fn_data[23:16] = i_bus_addr[23:16];
      fn_oe[23:16]   = {8{~i_bus_released}};
      // Port 3: strobes, hold handshake, ready and clock.
      fn_own[31:24] = 8'hff;
      fn_data[24 + `PM_BIT_ALE] = i_bus_ale;
      fn_data[24 + `PM_BIT_RD]  = i_bus_rd;
      fn_data[24 + `PM_BIT_WR_LOW]  = i_bus_write_strobe_low_byte;
      fn_data[24 + `PM_BIT_WR_HIGH] = i_bus_write_strobe_high_byte;
      fn_data[24 + `PM_BIT_HACK] = i_bus_released;
      fn_data[24 + `PM_BIT_CLK] = i_bus_clk;
      fn_oe[24 + `PM_BIT_ALE] = ~i_bus_released;
      fn_oe[24 + `PM_BIT_RD]  = ~i_bus_released;
      fn_oe[24 + `PM_BIT_WR_LOW]  = ~i_bus_released;
      fn_oe[24 + `PM_BIT_WR_HIGH] = ~i_bus_released;
      fn_oe[24 + `PM_BIT_HACK] = 1'b1;
      fn_oe[24 + `PM_BIT_CLK] = 1'b1;
      // Hold request and ready stay inputs with no driver.
      fn_oe[24 + `PM_BIT_HREQ] = 1'b0;
      fn_oe[24 + `PM_BIT_RDY]  = 1'b0;
    end
    // Port 4 serial and pulse functions, each gated by its own enable.
    fn_own[32 + `PM_BIT_A0_TX]  = i_async0_tx_en;
    fn_data[32 + `PM_BIT_A0_TX] = i_async0_tx;
    fn_oe[32 + `PM_BIT_A0_TX]   = 1'b1;
    fn_own[32 + `PM_BIT_A1_TX]  = i_async1_tx_en;
    fn_data[32 + `PM_BIT_A1_TX] = i_async1_tx;
    fn_oe[32 + `PM_BIT_A1_TX]   = 1'b1;
    fn_own[32 + `PM_BIT_A0_CLK]  = i_async0_clk_en;
    fn_data[32 + `PM_BIT_A0_CLK] = i_async0_clk;
    fn_oe[32 + `PM_BIT_A0_CLK]   = 1'b1;
    fn_own[32 + `PM_BIT_A1_CLK]  = i_async1_clk_en;
    fn_data[32 + `PM_BIT_A1_CLK] = i_async1_clk;
    fn_oe[32 + `PM_BIT_A1_CLK]   = 1'b1;
    fn_own[32 + `PM_BIT_PULSE0]  = i_pulse_out_en[0];
    fn_data[32 + `PM_BIT_PULSE0] = i_pulse_out_pair[0];
    fn_oe[32 + `PM_BIT_PULSE0]   = 1'b1;
    fn_own[32 + `PM_BIT_PULSE1]  = i_pulse_out_en[1];
    fn_data[32 + `PM_BIT_PULSE1] = i_pulse_out_pair[1];
    fn_oe[32 + `PM_BIT_PULSE1]   = 1'b1;
    // Port 5 clocked channel outputs.
    fn_own[40 + `PM_BIT_C0_TX]  = i_clocked0_en;
    fn_data[40 + `PM_BIT_C0_TX] = i_clocked0_tx;
    fn_oe[40 + `PM_BIT_C0_TX]   = 1'b1;
    fn_own[40 + `PM_BIT_C0_CLK]  = i_clocked0_en;
    fn_data[40 + `PM_BIT_C0_CLK] = i_clocked0_clk;
    fn_oe[40 + `PM_BIT_C0_CLK]   = 1'b1;
    // Hardware standby floats every pad.
    if (i_hw_standby_input) begin
      fn_own = 48'hffff_ffff_ffff;
      fn_oe  = 48'h0000_0000_0000;
    end
  end

  // One output stage per pin.
  genvar g;
  generate
    for (g = 0; g < 48; g = g + 1) begin : g_pin
      if (g < 16) begin : g_pu
        pin_cell u_cell (
          .i_ref_clk    (i_ref_clk),
          .i_srst       (i_srst),
          .i_port_data  (i_port_data[g]),
          .i_port_dir   (i_port_dir[g]),
          .i_pullup_sel (pullup_sel[g]),
          .i_open_drain (open_drain[g]),
          .i_fn_own     (fn_own[g]),
          .i_fn_data    (fn_data[g]),
          .i_fn_oe      (fn_oe[g]),
          .o_pad_out_ff (o_pad_out[g]),
          .o_pad_oe_ff  (o_pad_oe[g]),
          .o_pullup_ff  (pullup_all[g])
        );
      end else begin : g_np
        pin_cell u_cell (
          .i_ref_clk    (i_ref_clk),
          .i_srst       (i_srst),
          .i_port_data  (i_port_data[g]),
          .i_port_dir   (i_port_dir[g]),
          .i_pullup_sel (pullup_sel[g]),
          .i_open_drain (open_drain[g]),
          .i_fn_own     (fn_own[g]),
          .i_fn_data    (fn_data[g]),
          .i_fn_oe      (fn_oe[g]),
          .o_pad_out_ff (o_pad_out[g]),
          .o_pad_oe_ff  (o_pad_oe[g]),
          .o_pullup_ff  ()
        );
      end
    end
  endgenerate

  // Input side: receive pins are sampled every cycle, whatever the port does.
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_port_read_ff     <= 48'h0000_0000_0000;
      o_bus_rdata_ff     <= 16'h0000;
      o_hold_request_ff  <= 1'b0;
      o_bus_ready_ff     <= 1'b0;
      o_ext_bus_mode_ff  <= 1'b0;
      o_hw_standby_ff    <= 1'b0;
      o_async0_rx_ff     <= 1'b0;
      o_async1_rx_ff     <= 1'b0;
      o_async0_clk_in_ff <= 1'b0;
      o_async1_clk_in_ff <= 1'b0;
      o_clocked0_rx_ff   <= 1'b0;
      o_clocked1_rx_ff   <= 1'b0;
    end else begin
      o_port_read_ff     <= i_pad_in;
      o_bus_rdata_ff     <= i_pad_in[15:0];
      o_hold_request_ff  <= ext & i_pad_in[24 + `PM_BIT_HREQ];
      // Ready reads high outside bus mode so no access can stall.
      o_bus_ready_ff     <= ~ext | i_pad_in[24 + `PM_BIT_RDY];
      o_ext_bus_mode_ff  <= ext;
      o_hw_standby_ff    <= i_hw_standby_input;
      o_async0_rx_ff     <= i_pad_in[32 + `PM_BIT_A0_RX];
      o_async1_rx_ff     <= i_pad_in[32 + `PM_BIT_A1_RX];
      o_async0_clk_in_ff <= i_pad_in[32 + `PM_BIT_A0_CLK];
      o_async1_clk_in_ff <= i_pad_in[32 + `PM_BIT_A1_CLK];
      o_clocked0_rx_ff   <= i_pad_in[40 + `PM_BIT_C0_RX];
      o_clocked1_rx_ff   <= i_pad_in[40 + `PM_BIT_C1_RX];
    end
  end
endmodule
`default_nettype wire

// *** pkg/pin_mux_defines.vh ***
// Overview of operation
// - Port 0 carries low address, then low data.
// - Port 1 carries middle address, then high data.
// - Port 2 drives high address byte in bus mode.
// - Port 3 bit 0 drives address latch enable.
// - Port 3 bit 1 drives read strobe.
// - Port 3 bit 2 drives low-byte write strobe.
// - Port 3 bit 3 drives high-byte write strobe.
// - Hold acknowledge on bit 5 after bus release.
// - Port 3 bit 7 outputs the bus clock.
// - Pull-ups on ports 0, 1 only for inputs.
// - Port 4 bits selectable open-drain per bit.
// - Async transmit reaches pin only when enabled.
// - Async clock pin driven only when enabled.
// - Pulse waveforms on port 4 bits 6, 7 when enabled.
// - Serial receive pins are sampled continuously.
// - Clocked channel output pins only when enabled.
`ifndef PIN_MUX_DEFINES_VH
`define PIN_MUX_DEFINES_VH
`define PM_MODE_EXT_BUS   3'h1
`define PM_BIT_ALE        0
`define PM_BIT_RD         1
`define PM_BIT_WR_LOW     2
`define PM_BIT_WR_HIGH    3
`define PM_BIT_HREQ       4
`define PM_BIT_HACK       5
`define PM_BIT_RDY        6
`define PM_BIT_CLK        7
`define PM_BIT_A0_RX      0
`define PM_BIT_A0_TX      1
`define PM_BIT_A0_CLK     2
`define PM_BIT_A1_RX      3
`define PM_BIT_A1_TX      4
`define PM_BIT_A1_CLK     5
`define PM_BIT_PULSE0     6
`define PM_BIT_PULSE1     7
`define PM_BIT_C0_RX      0
`define PM_BIT_C0_TX      1
`define PM_BIT_C0_CLK     2
`define PM_BIT_C1_RX      3
`define PM_RST_BYTE       8'h00
`endif

// *** test/ext_bus_memory_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// External memory and bus master on the multiplexed bus, seen at the pads.
module ext_bus_memory_model (
  input  wire logic        i_ref_clk,
  input  wire logic [47:0] i_pad_out,
  input  wire logic [47:0] i_pad_oe,
  input  wire logic        i_hold_req,
  input  wire logic        i_slow,
  output logic      [47:0] o_pad_val,
  output logic      [47:0] o_pad_en
);
  logic [15:0] adr_ff = '0;
  wire         rd     = i_pad_oe[25] && i_pad_out[25];
  // The low address is caught while the latch enable is high.
  always @(posedge i_ref_clk) begin
    if (i_pad_oe[24] && i_pad_out[24]) adr_ff <= i_pad_out[15:0];
  end
  // Data lines are driven only during a read, so a stale value cannot pass.
  assign o_pad_en  = {17'h0, 1'b1, 1'b0, 1'b1, 12'h0, {16{rd}}};
  assign o_pad_val = {17'h0, !(i_slow && rd), 1'b0, i_hold_req, 12'h0, adr_ff ^ 16'h5a5a};
endmodule
`default_nettype wire

// *** test/pin_mux_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of how the bus and the peripherals take over the pads.
module pin_mux_checker (
  input wire logic        i_ref_clk,
  input wire logic        i_srst,
  input wire logic        i_hw_standby_input,
  input wire logic [2:0]  i_mode_select_inputs,
  input wire logic [7:0]  i_port0_pullup_select,
  input wire logic [7:0]  i_port1_pullup_select,
  input wire logic [7:0]  i_port4_open_drain_select,
  input wire logic [23:0] i_bus_addr,
  input wire logic [15:0] i_bus_wdata,
  input wire logic        i_bus_addr_phase,
  input wire logic        i_bus_data_drive,
  input wire logic        i_bus_ale,
  input wire logic        i_bus_rd,
  input wire logic        i_bus_write_strobe_low_byte,
  input wire logic        i_bus_write_strobe_high_byte,
  input wire logic        i_bus_released,
  input wire logic        i_async0_tx,
  input wire logic        i_async0_tx_en,
  input wire logic [47:0] i_pad_in,
  input wire logic [47:0] o_pad_out,
  input wire logic [47:0] o_pad_oe,
  input wire logic [15:0] o_pad_pullup,
  input wire logic        o_hold_request_ff
);
  // Bus ownership is only judged while standby is not forcing every pad off.
  wire       own  = (i_mode_select_inputs == 3'h1) && !i_hw_standby_input;
  wire [3:0] strb = {i_bus_write_strobe_high_byte, i_bus_write_strobe_low_byte,
                     i_bus_rd, i_bus_ale};
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  AST_ADDR_OUT: assert property (
    own && i_bus_addr_phase && !i_bus_released |=>
    o_pad_out[23:0] == $past(i_bus_addr) && o_pad_oe[23:0] == 24'hff_ffff)
    else $error("address not on ports 0 to 2");
  AST_DATA_OUT: assert property (
    own && i_bus_data_drive && !i_bus_addr_phase && !i_bus_released |=>
    o_pad_out[15:0] == $past(i_bus_wdata) && o_pad_oe[15:0] == 16'hffff)
    else $error("write data not on ports 0 and 1");
  AST_STROBES: assert property (
    own && !i_bus_released |=> o_pad_out[27:24] == $past(strb) && o_pad_oe[27:24] == 4'hf)
    else $error("bus strobes not on port 3");
  AST_HOLD_ACK: assert property (
    own |=> o_pad_out[29] == $past(i_bus_released) && o_pad_oe[29] &&
    (!$past(i_bus_released) || o_pad_oe[23:0] == 24'h0))
    else $error("hold acknowledge or bus release wrong");
  AST_HOLD_REQ: assert property (
    own && i_pad_in[28] |=> o_hold_request_ff) else $error("hold request lost");
  AST_PULLUP: assert property (
    !i_hw_standby_input |=> o_pad_pullup ==
    ({$past(i_port1_pullup_select), $past(i_port0_pullup_select)} & ~o_pad_oe[15:0]))
    else $error("pull-up applied to a driven pin");
  AST_ASYNC_TX: assert property (
    !i_hw_standby_input && i_async0_tx_en && !i_port4_open_drain_select[1] |=>
    o_pad_out[33] == $past(i_async0_tx) && o_pad_oe[33])
    else $error("async transmit not on its pin");
  AST_OPEN_DRAIN: assert property (
    !i_hw_standby_input && i_async0_tx_en && i_port4_open_drain_select[1] && i_async0_tx
    |=> !o_pad_oe[33]) else $error("open-drain pin drives a high");
  AST_STANDBY: assert property (
    i_hw_standby_input |=> o_pad_oe == 48'h0) else $error("pads driven in standby");
endmodule
bind port_bus_pin_function_select pin_mux_checker u_chk (.*);
`default_nettype wire

// *** test/port_bus_pin_function_select_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module port_bus_pin_function_select_tb_top;
  // Stimulus carries the port names so the instance binds by name.
  logic i_ref_clk = '0, i_srst = '1, i_hw_standby_input = '0, i_bus_addr_phase = '0;
  logic i_bus_data_drive = '0, i_bus_ale = '0, i_bus_rd = '0;
  logic i_bus_write_strobe_low_byte = '0, i_bus_write_strobe_high_byte = '0;
  logic i_bus_released = '0, i_bus_clk = '0, i_async0_tx = '0, i_async0_tx_en = '0;
  logic i_async0_clk = '0, i_async0_clk_en = '0, i_async1_tx = '0, i_async1_tx_en = '0;
  logic i_async1_clk = '0, i_async1_clk_en = '0, i_clocked0_tx = '0, i_clocked0_clk = '0;
  logic i_clocked0_en = '0, hreq = '0, slow = '0, tog = '0;
  logic [1:0]  i_pulse_out_pair = '0, i_pulse_out_en = '0;
  logic [2:0]  i_mode_select_inputs = '0;
  logic [7:0]  i_port0_pullup_select = '0, i_port1_pullup_select = '0;
  logic [7:0]  i_port4_open_drain_select = '0;
  logic [15:0] i_bus_wdata = '0;
  logic [23:0] i_bus_addr = '0;
  logic [47:0] i_port_data = '0, i_port_dir = '0;
  wire  [47:0] i_pad_in, o_pad_out, o_pad_oe, o_port_read_ff, pval, pen;
  wire  [15:0] o_pad_pullup, o_bus_rdata_ff;
  wire o_hold_request_ff, o_bus_ready_ff, o_ext_bus_mode_ff, o_hw_standby_ff, o_async0_rx_ff;
  wire o_async1_rx_ff, o_async0_clk_in_ff, o_async1_clk_in_ff, o_clocked0_rx_ff, o_clocked1_rx_ff;
  // Decoded receive and clock inputs: both async receives, both async clocks, then both clocked receives.
  wire  [5:0]  rx_pins = {o_async0_rx_ff, o_async1_rx_ff, o_async0_clk_in_ff,
                          o_async1_clk_in_ff, o_clocked0_rx_ff, o_clocked1_rx_ff};
  int err_count = 0, check_count = 0;
  always #5 i_ref_clk = ~i_ref_clk;
  // Released lines toggle every cycle so a held old value cannot pass.
  always @(posedge i_ref_clk) tog <= ~tog;
  assign i_pad_in = (o_pad_oe & o_pad_out) | (~o_pad_oe & pen & pval) | (~o_pad_oe & ~pen & {48{tog}});
  port_bus_pin_function_select u_dut (.*);
  ext_bus_memory_model u_mem (.i_ref_clk(i_ref_clk), .i_pad_out(o_pad_out), .i_pad_oe(o_pad_oe),
    .i_hold_req(hreq), .i_slow(slow), .o_pad_val(pval), .o_pad_en(pen));
  // One comparison; a mismatch is counted and shown at once.
  task automatic chk(input string n, input logic [47:0] s, input logic [47:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // Outputs answer one edge after their inputs; look just after that edge.
  task automatic settle(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  // Single chip: ports follow their registers, pull-ups only on input pins.
  task automatic t_gpio;
    @(posedge i_ref_clk);
    i_port_data <= 48'hfedc_ba98_7654;
    i_port_dir <= 48'hffff_ffff_ff0f;
    i_port0_pullup_select <= 8'hff;
    i_port1_pullup_select <= 8'hff;
    settle(1);
    chk("gpio_oe", o_pad_oe, 48'hffff_ffff_ff0f);
    chk("gpio_out", o_pad_out & i_port_dir, 48'hfedc_ba98_7604);
    chk("pullup", o_pad_pullup, 16'h00f0);
    // The read side sees the driven pads one edge after the pads themselves.
    settle(1);
    chk("read", o_port_read_ff & 48'hffff_ffff_ff0f, 48'hfedc_ba98_7604);
    chk("rx_pins", rx_pins, 6'h19);
    $display("test gpio done");
  endtask
  // Peripherals take port 4 and 5 pins, then all but the async 0 transmit hand them back.
  task automatic t_periph;
    @(posedge i_ref_clk);
    i_port_data <= '0;
    i_port_dir <= 48'h0000_ffff_ff0f;
    i_async0_tx <= 1'b1;
    i_async0_tx_en <= 1'b1;
    i_async0_clk_en <= 1'b1;
    i_async1_tx_en <= 1'b1;
    i_async1_clk <= 1'b1;
    i_async1_clk_en <= 1'b1;
    i_pulse_out_pair <= 2'b10;
    i_pulse_out_en <= 2'b11;
    i_clocked0_tx <= 1'b1;
    i_clocked0_en <= 1'b1;
    settle(1);
    chk("fn_oe", o_pad_oe[47:32], 16'h06f6);
    chk("fn_out", o_pad_out[47:32] & 16'h06f6, 16'h02a2);
    @(posedge i_ref_clk);
    i_async0_clk_en <= 1'b0;
    i_async1_tx_en <= 1'b0;
    i_async1_clk_en <= 1'b0;
    i_pulse_out_en <= 2'b00;
    i_clocked0_en <= 1'b0;
    i_port_dir <= 48'h00ff_ffff_ff0f;
    i_port_data <= 48'h00f0_0000_0000;
    i_port4_open_drain_select <= 8'hff;
    settle(1);
    chk("od_oe", o_pad_oe[47:32], 16'h000d);
    $display("test periph done");
  endtask
  // External bus: address, write, slow read, hold, then standby and wake.
  task automatic t_bus;
    @(posedge i_ref_clk);
    i_mode_select_inputs <= 3'h1;
    i_port_dir <= '0;
    i_port4_open_drain_select <= '0;
    i_bus_addr <= 24'h12_3456;
    i_bus_addr_phase <= 1'b1;
    i_bus_ale <= 1'b1;
    i_bus_clk <= 1'b1;
    settle(1);
    chk("addr", o_pad_out[24:0], 25'h112_3456);
    chk("clk_mode", {o_pad_out[31], o_ext_bus_mode_ff}, 2'b11);
    @(posedge i_ref_clk);
    i_bus_addr_phase <= 1'b0;
    i_bus_ale <= 1'b0;
    i_bus_data_drive <= 1'b1;
    i_bus_wdata <= 16'hbeef;
    i_bus_write_strobe_low_byte <= 1'b1;
    i_bus_write_strobe_high_byte <= 1'b1;
    settle(1);
    chk("wdata", {o_pad_out[27:26], o_pad_out[15:0]}, 18'h3_beef);
    @(posedge i_ref_clk);
    i_bus_data_drive <= 1'b0;
    i_bus_write_strobe_low_byte <= 1'b0;
    i_bus_write_strobe_high_byte <= 1'b0;
    i_bus_rd <= 1'b1;
    settle(2);
    chk("rdata", o_bus_rdata_ff, 16'h3456 ^ 16'h5a5a);
    @(posedge i_ref_clk);
    slow <= 1'b1;
    settle(1);
    chk("ready", o_bus_ready_ff, 1'b0);
    @(posedge i_ref_clk);
    slow <= 1'b0;
    i_bus_rd <= 1'b0;
    hreq <= 1'b1;
    i_bus_released <= 1'b1;
    settle(1);
    chk("hold", {o_hold_request_ff, o_pad_out[29], o_pad_oe[29], o_bus_ready_ff}, 4'hf);
    chk("release", o_pad_oe[23:0], 24'h0);
    @(posedge i_ref_clk);
    hreq <= 1'b0;
    i_bus_released <= 1'b0;
    i_hw_standby_input <= 1'b1;
    settle(1);
    chk("standby", {o_hw_standby_ff, |o_pad_oe}, 2'b10);
    // Leaving standby hands the pads back to the bus and the active channel.
    @(posedge i_ref_clk);
    i_hw_standby_input <= 1'b0;
    settle(1);
    chk("wake_oe", o_pad_oe, 48'h0002_afff_0000);
    $display("test bus done");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Reset for six edges, then run each scenario in turn.
  initial begin
    repeat (6) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    #1;
    chk("reset_oe", o_pad_oe, 48'h0);
    t_gpio();
    t_periph();
    t_bus();
    finish_test();
  end
endmodule
`default_nettype wire
